// >>> src/lbh_handler.v
// Purpose: module-side handler for the loopback diagnostics command
// Assumes: host writes header bytes, then the low command byte starts it
// Notes: read data returns one cycle after the read strobe
//
// Functional notes
// (R1) Host requests with identifier 0380h, both payload lengths zero.
// (R2) Header check byte covers bytes 128-132; correct value is 7Ch.
// (R3) Reply length and reply check may be preloaded; module ignores them.
// (R4) Command-complete flag goes to one when handling ends, any outcome.
// (R5) Busy codes 81h captured, 82h checking, 83h executing.
// (R6) Final 01h on success, 40h on unspecific failure.
// (R7) Out-of-range parameter or unsupported function ends with 42h.
// (R8) Check byte mismatch ends with 45h.
// (R9) Reply writes zero length and zero check byte.
// (R10) Bytes 136-255 of the message page are ignored both ways.
// (R11) Flag held clear, busy code shown from capture until final code.
`timescale 1ns/10ps
`include "lbh_defs.vh"

module lbh_handler (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // register port
    input wire [7:0] reg_page,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // status view
    output reg command_complete_flag,
    output reg [7:0] command_status,
    output reg busy
);

    // ==========================================================
    // states
    localparam [4:0] S_IDLE = 5'b0_0001;
    localparam [4:0] S_CAPT = 5'b0_0010;
    localparam [4:0] S_CHECK = 5'b0_0100;
    localparam [4:0] S_EXEC = 5'b0_1000;
    localparam [4:0] S_DONE = 5'b1_0000;

    // ==========================================================
    // reset release
    reg rst_meta_reg;
    reg rst_sync_reg;

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire rst_n_int;
    assign rst_n_int = rst_sync_reg;

    // ==========================================================
    // decode
    wire msg_pg;
    wire st_pg;
    wire wr_msg;
    wire start_cmd;

    assign msg_pg = (reg_page == `LBH_PAGE_MSG);
    assign st_pg = (reg_page == `LBH_PAGE_STATUS);
    assign wr_msg = reg_wr & msg_pg;
    assign start_cmd = wr_msg & (reg_addr == `LBH_OFS_CMD_LO);

    // ==========================================================
    // header bytes
    reg [15:0] cmd_id_reg;
    reg [15:0] epl_len_reg;
    reg [7:0] lpl_len_reg;
    reg [7:0] chk_reg;
    reg [7:0] rpl_len_reg;
    reg [7:0] rpl_chk_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [7:0] status_next;
    reg chk_bad_reg;
    reg overrun_reg;
    wire [7:0] chk_calc;
    wire in_busy;

    assign in_busy = (state_reg != S_IDLE) && (state_reg != S_DONE);

    // a start that arrives while busy is never taken as a new command
    wire start_ok;
    wire start_late;

    assign start_ok = start_cmd & ~in_busy;
    assign start_late = start_cmd & in_busy;

    lbh_chk_calc u_chk (
        .cmd_id(cmd_id_reg),
        .epl_len(epl_len_reg),
        .lpl_len(lpl_len_reg),
        .chk_code(chk_calc)
    );

    // header writes are blocked while busy so the checked bytes stay stable
    always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            cmd_id_reg <= 16'h0000;
            epl_len_reg <= 16'h0000;
            lpl_len_reg <= 8'h00;
            chk_reg <= 8'h00;
        end else if (wr_msg && !in_busy) begin
            case (reg_addr)
                `LBH_OFS_CMD_HI: cmd_id_reg[15:8] <= reg_wdata;
                `LBH_OFS_CMD_LO: cmd_id_reg[7:0] <= reg_wdata;
                `LBH_OFS_EPL_HI: epl_len_reg[15:8] <= reg_wdata;
                `LBH_OFS_EPL_LO: epl_len_reg[7:0] <= reg_wdata;
                `LBH_OFS_LPL: lpl_len_reg <= reg_wdata;
                `LBH_OFS_CHK: chk_reg <= reg_wdata;
                default: chk_reg <= chk_reg; // (R10)
            endcase
        end
    end

    // ==========================================================
    // reply bytes
    // the host may preload these to see later that the module overwrote them;
    // nothing in the handler reads them for its own use
    always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            rpl_len_reg <= 8'h00;
            rpl_chk_reg <= 8'h00;
        end else if (state_reg == S_EXEC) begin
            rpl_len_reg <= `LBH_RPL_EMPTY; // (R9)
            rpl_chk_reg <= `LBH_RPL_EMPTY; // (R9)
        end else if (wr_msg && !in_busy) begin
            if (reg_addr == `LBH_OFS_RPL_LEN) begin
                rpl_len_reg <= reg_wdata; // (R3)
            end
            if (reg_addr == `LBH_OFS_RPL_CHK) begin
                rpl_chk_reg <= reg_wdata; // (R3)
            end
        end
    end

    // ==========================================================
    // header field checks
    // each field is compared on its own; a wrong identifier and a wrong
    // length both end on the same parameter error code
    wire id_ok;
    wire epl_ok;
    wire lpl_ok;
    wire hdr_ok;
    wire chk_match;

    assign id_ok = (cmd_id_reg == `LBH_CMD_LOOPBACK); // (R7)
    assign epl_ok = (epl_len_reg == `LBH_EPL_NONE); // (R7)
    assign lpl_ok = (lpl_len_reg == `LBH_LPL_NONE); // (R7)
    assign hdr_ok = id_ok & epl_ok & lpl_ok;
    // only header bytes are summed: payload bytes are never stored
    assign chk_match = (chk_calc == chk_reg); // (R2)

    // ==========================================================
    // final code
    // a late start outranks the header checks: the run cannot be trusted
    reg [7:0] final_code;

    always @* begin
        final_code = `LBH_ST_SUCCESS; // (R6)
        if (overrun_reg) begin
            final_code = `LBH_ST_FAIL; // (R6)
        end else if (!hdr_ok) begin
            final_code = `LBH_ST_PARAM; // (R7)
        end
    end

    // ==========================================================
    // command sequence
    always @* begin
        state_next = state_reg;
        status_next = command_status;
        case (state_reg)
            S_IDLE, S_DONE: begin
                if (start_cmd) begin
                    state_next = S_CAPT;
                    status_next = `LBH_ST_CAPTURED; // (R5)
                end
            end
            S_CAPT: begin
                state_next = S_CHECK;
                status_next = `LBH_ST_CHECKING; // (R5)
            end
            S_CHECK: begin
                if (chk_bad_reg) begin
                    state_next = S_DONE;
                    status_next = `LBH_ST_CHK_ERR; // (R8)
                end else begin
                    state_next = S_EXEC;
                    status_next = `LBH_ST_EXECUTING; // (R5)
                end
            end
            S_EXEC: begin
                state_next = S_DONE;
                status_next = final_code; // (R6) (R7)
            end
            default: begin
                state_next = S_IDLE;
                status_next = `LBH_ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_reg <= S_IDLE;
            command_status <= `LBH_ST_IDLE;
            busy <= 1'b0;
        end else begin
            state_reg <= state_next;
            command_status <= status_next;
            busy <= (state_next != S_IDLE) && (state_next != S_DONE); // (R11)
        end
    end

    // ==========================================================
    // check result and late start
    // compared one cycle after capture, header bytes now frozen
    always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            chk_bad_reg <= 1'b0;
        end else if (state_reg == S_CAPT) begin
            chk_bad_reg <= ~chk_match; // (R2) (R8)
        end
    end

    // a new start while busy cannot be honoured; in capture or check it fails the run (40h) unless the check byte fails; in execute it is lost
    always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            overrun_reg <= 1'b0;
        end else if (start_late) begin
            overrun_reg <= 1'b1; // (R6)
        end else if (start_ok) begin
            overrun_reg <= 1'b0;
        end
    end

    // ==========================================================
    // completion flag, cleared by reading its byte
    wire flag_rd;
    assign flag_rd = reg_rd & st_pg & (reg_addr == `LBH_OFS_FLAG);

    // set wins over every clear, so a read in the completion cycle loses nothing
    wire finish_now;
    assign finish_now = (state_next == S_DONE) && (state_reg != S_DONE);

    always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            command_complete_flag <= 1'b0;
        end else if (finish_now) begin
            command_complete_flag <= 1'b1; // (R4)
        end else if (start_cmd || flag_rd || in_busy) begin
            command_complete_flag <= 1'b0; // (R11)
        end
    end

    // ==========================================================
    // read port
    // the byte is picked combinationally and registered once, so read data
    // comes from a flip-flop one cycle after the strobe
    reg [7:0] st_byte;
    reg [7:0] msg_byte;

    always @* begin
        case (reg_addr)
            `LBH_OFS_FLAG: st_byte = {1'b0, command_complete_flag, 6'b00_0000};
            `LBH_OFS_STATUS: st_byte = command_status;
            default: st_byte = 8'h00;
        endcase
    end

    always @* begin
        case (reg_addr)
            `LBH_OFS_CMD_HI: msg_byte = cmd_id_reg[15:8];
            `LBH_OFS_CMD_LO: msg_byte = cmd_id_reg[7:0];
            `LBH_OFS_EPL_HI: msg_byte = epl_len_reg[15:8];
            `LBH_OFS_EPL_LO: msg_byte = epl_len_reg[7:0];
            `LBH_OFS_LPL: msg_byte = lpl_len_reg;
            `LBH_OFS_CHK: msg_byte = chk_reg;
            `LBH_OFS_RPL_LEN: msg_byte = rpl_len_reg;
            `LBH_OFS_RPL_CHK: msg_byte = rpl_chk_reg;
            default: msg_byte = 8'h00; // (R10)
        endcase
    end

    always @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && st_pg) begin
            reg_rdata <= st_byte;
        end else if (reg_rd && msg_pg) begin
            reg_rdata <= msg_byte;
        end else if (reg_rd) begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// >>> include/lbh_defs.vh
// Purpose: constants for the loopback command handler
// Assumes: byte-wide management register port, page plus byte address
// Notes: status codes are the two-bit class followed by the six-bit code
`ifndef LBH_DEFS_VH
`define LBH_DEFS_VH

// ==========================================================
// page selects
`define LBH_PAGE_STATUS 8'h00
`define LBH_PAGE_MSG 8'h9F

// ==========================================================
// byte offsets
`define LBH_OFS_FLAG 8'h08
`define LBH_FLAG_BIT 6
`define LBH_OFS_STATUS 8'h25
`define LBH_OFS_CMD_HI 8'h80
`define LBH_OFS_CMD_LO 8'h81
`define LBH_OFS_EPL_HI 8'h82
`define LBH_OFS_EPL_LO 8'h83
`define LBH_OFS_LPL 8'h84
`define LBH_OFS_CHK 8'h85
`define LBH_OFS_RPL_LEN 8'h86
`define LBH_OFS_RPL_CHK 8'h87

// ==========================================================
// command values
`define LBH_CMD_LOOPBACK 16'h0380
`define LBH_EPL_NONE 16'h0000
`define LBH_LPL_NONE 8'h00
`define LBH_RPL_EMPTY 8'h00

// ==========================================================
// status codes
`define LBH_ST_IDLE 8'h00
`define LBH_ST_CAPTURED 8'h81
`define LBH_ST_CHECKING 8'h82
`define LBH_ST_EXECUTING 8'h83
`define LBH_ST_SUCCESS 8'h01
`define LBH_ST_FAIL 8'h40
`define LBH_ST_PARAM 8'h42
`define LBH_ST_CHK_ERR 8'h45

`endif

// >>> src/lbh_chk_calc.v
// Purpose: header check code, ones complement of the byte sum
// Assumes: no local payload bytes contribute (length is checked apart)
// Notes: sum is kept to eight bits, carries are dropped
`timescale 1ns/10ps

module lbh_chk_calc (
    // header bytes
    input wire [15:0] cmd_id,
    input wire [15:0] epl_len,
    input wire [7:0] lpl_len,
    // result
    output wire [7:0] chk_code
);

    wire [7:0] sum;

    assign sum = cmd_id[15:8] + cmd_id[7:0] + epl_len[15:8] + epl_len[7:0] + lpl_len; // (R2)
    assign chk_code = ~sum;

endmodule

// >>> tb/lbh_monitor.sv
// Purpose: port checks for the loopback handler
// Assumes: start is a write of 9Fh:81h
// Notes: timing follows the four-cycle walk
`timescale 1ns/10ps
module lbh_monitor (
    // clock and reset
    input wire ref_clk,
    input wire rstn,
    // register port
    input wire [7:0] reg_page,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // status view
    input wire command_complete_flag,
    input wire [7:0] command_status,
    input wire busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire start = reg_wr && reg_page == 8'h9f && reg_addr == 8'h81;
    wire rpl_rd = reg_rd && reg_page == 8'h9f && reg_addr[7:1] == 7'h43;
    a_start_captured: assert property (start && !busy |=> busy && command_status == 8'h81)
        else $error("start not captured");
    a_capture_to_check: assert property (busy && command_status == 8'h81 |=> command_status == 8'h82)
        else $error("no checking code");
    a_check_fail: assert property ((busy && command_status == 8'h82) ##1 !busy |->
        command_status == 8'h45 && command_complete_flag) else $error("bad check end");
    a_exec_final: assert property (command_status == 8'h83 |=>
        !busy && command_status inside {8'h01, 8'h40, 8'h42}) else $error("bad final code");
    a_busy_no_flag: assert property (busy |-> !command_complete_flag)
        else $error("flag set while busy");
    a_busy_code: assert property (busy |-> command_status[7:6] == 2'b10)
        else $error("busy without busy code");
    a_done_flag: assert property ($fell(busy) |-> command_complete_flag)
        else $error("flag missing at end");
    a_done_bound: assert property (start && !busy |-> ##[3:4] !busy)
        else $error("command too slow");
    a_reply_empty: assert property (rpl_rd && !busy && command_status == 8'h01 |=>
        reg_rdata == 8'h00) else $error("reply not empty");
endmodule

bind lbh_handler lbh_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .command_complete_flag(command_complete_flag),
    .command_status(command_status), .busy(busy));

// >>> tb/lbh_host_model.sv
// Purpose: host side of the register port
// Assumes: strobes taken on the rising edge
// Notes: write data inverted on release so stale bytes never look valid
`timescale 1ns/10ps
module lbh_host_model (
    // clock
    input wire ref_clk,
    // register port
    output reg [7:0] reg_page = 8'h00,
    output reg [7:0] reg_addr = 8'h00,
    output reg [7:0] reg_wdata = 8'h00,
    output reg reg_wr = 1'b0,
    output reg reg_rd = 1'b0,
    input wire [7:0] reg_rdata
);
    task wr(input [7:0] pg, input [7:0] ad, input [7:0] d);
        begin
            @(posedge ref_clk);
            #1;
            reg_page = pg;
            reg_addr = ad;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge ref_clk);
            #1;
            reg_wr = 1'b0;
            reg_wdata = ~d;
        end
    endtask
    task rd(input [7:0] pg, input [7:0] ad, output [7:0] d);
        begin
            @(posedge ref_clk);
            #1;
            reg_page = pg;
            reg_addr = ad;
            reg_rd = 1'b1;
            @(posedge ref_clk);
            #1;
            reg_rd = 1'b0;
            d = reg_rdata;
        end
    endtask
endmodule

// >>> tb/tb.sv
// Purpose: command sequences through the register port
// Assumes: status at 00h:25h, flag at 00h:08h bit 6
// Notes: overlap case restarts while busy
`timescale 1ns/10ps
module tb;
    reg ref_clk;
    reg rstn;
    wire [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, command_status;
    wire reg_wr, reg_rd, command_complete_flag, busy;
    integer failures = 0;
    integer n_checks = 0;
    reg [7:0] rv;
    lbh_handler dut (.ref_clk(ref_clk), .rstn(rstn), .reg_page(reg_page),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .command_complete_flag(command_complete_flag),
        .command_status(command_status), .busy(busy));
    lbh_host_model host (.ref_clk(ref_clk), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task results;
        begin
            if (failures == 0 && n_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task check(input [63:0] nm, input [7:0] exp, input [7:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task run(input [15:0] id, input [7:0] local_payload, input [7:0] ck, input ov, input [7:0] exp);
        integer k;
        begin
            host.wr(8'h9f, 8'h86, 8'ha5);
            host.wr(8'h9f, 8'h87, 8'h5a);
            host.wr(8'h9f, 8'h80, id[15:8]);
            host.wr(8'h9f, 8'h82, 8'h00);
            host.wr(8'h9f, 8'h83, 8'h00);
            host.wr(8'h9f, 8'h84, local_payload);
            host.wr(8'h9f, 8'h85, ck);
            host.wr(8'h9f, 8'h81, id[7:0]);
            if (ov) host.wr(8'h9f, 8'h81, id[7:0]);
            // bounded wait, a hang ends the run
            for (k = 0; k < 20 && busy !== 1'b0; k = k + 1) begin
                @(posedge ref_clk);
                #1;
            end
            if (busy !== 1'b0) begin
                failures = failures + 1;
                results;
            end
            check("flag_pin", 8'h01, {7'h00, command_complete_flag});
            check("stat_pin", exp, command_status);
            host.rd(8'h00, 8'h25, rv);
            check("status", exp, rv);
            host.rd(8'h00, 8'h08, rv);
            check("flag", 8'h01, {7'h00, rv[6]});
            host.rd(8'h00, 8'h08, rv);
            check("flag_clr", 8'h00, {7'h00, rv[6]});
        end
    endtask
    initial begin
        rstn = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge ref_clk);
        run(16'h0380, 8'h00, 8'h7c, 1'b0, 8'h01);
        host.rd(8'h9f, 8'h86, rv);
        check("rpl_len", 8'h00, rv);
        host.rd(8'h9f, 8'h87, rv);
        check("rpl_chk", 8'h00, rv);
        run(16'h0380, 8'h00, 8'h7d, 1'b0, 8'h45);
        run(16'h0381, 8'h00, 8'h7b, 1'b0, 8'h42);
        run(16'h0380, 8'h01, 8'h7b, 1'b0, 8'h42);
        run(16'h0380, 8'h00, 8'h7c, 1'b1, 8'h40);
        host.wr(8'h9f, 8'h90, 8'h55);
        host.rd(8'h9f, 8'h90, rv);
        check("reserved", 8'h00, rv);
        // reset in mid-command must leave idle status
        host.wr(8'h9f, 8'h81, 8'h80);
        rstn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge ref_clk);
        host.rd(8'h00, 8'h25, rv);
        check("rst_stat", 8'h00, rv);
        results;
    end
endmodule
